//--- dssc_switch_control.sv
// Overview of operation
// - With the switch off, holding hold_button_n low for 0.3 s turns the switch on.
// - With the switch on, holding hold_button_n low for 1.8 s turns it off into deep sleep.
// - With the button released, a rising edge on wake_trigger turns the switch on after 0.8 ms.
// - With the button released and wake_trigger low, a rising sleep_trigger edge turns it off after 1.8 s.
// - After power is applied the switch starts off with the output grounded and inputs at idle.
// - The output discharge path is enabled exactly while the main switch is off.
// - After the turn-on delay the output rises through a controlled ramp of about 1 ms.
// - Undriven wake_trigger and sleep_trigger read as low and never make an edge.
// - Concurrent inputs are served by priority: button first, then wake, then sleep, except that a wake edge in the sleep delay beats a held button.
// - Releasing the button before the 1.8 s sleep hold keeps the switch on.
// - A button release during the sleep delay cancels turn-off; a later sleep edge restarts it.
`timescale 1ns/1ns
`default_nettype none

module dssc_switch_control #(
  parameter int HOLD_ON_CYCLES    = dssc_pkg::HOLD_ON_CYCLES,
  parameter int SLEEP_HOLD_CYCLES = dssc_pkg::SLEEP_HOLD_CYCLES,
  parameter int EDGE_ON_CYCLES    = dssc_pkg::EDGE_ON_CYCLES,
  parameter int EDGE_OFF_CYCLES   = dssc_pkg::EDGE_OFF_CYCLES,
  parameter int RAMP_CYCLES       = dssc_pkg::RAMP_CYCLES
) (
  input  wire logic                        clock,
  input  wire logic                        reset_n,
  input  wire logic                        clock_enable,
  input  wire logic                        hold_button_n,
  input  wire logic                        wake_trigger,
  input  wire logic                        sleep_trigger,
  output logic                             switch_enable,
  output logic                             discharge_enable,
  output logic [dssc_pkg::RAMP_W-1:0]      ramp_level
);
  localparam int W = dssc_pkg::CNT_W;
  localparam int RAMP_STEP_CYCLES = RAMP_CYCLES / 255;

  // Refused at elaboration: a count the 26-bit counters cannot hold, or a ramp too short to step
  if (HOLD_ON_CYCLES < 1 || SLEEP_HOLD_CYCLES < 1 || EDGE_ON_CYCLES < 1 || EDGE_OFF_CYCLES < 1 ||
      RAMP_STEP_CYCLES < 1 || SLEEP_HOLD_CYCLES >= (1 << W) || HOLD_ON_CYCLES >= (1 << W) ||
      EDGE_ON_CYCLES >= (1 << W) || EDGE_OFF_CYCLES >= (1 << W) || RAMP_CYCLES >= (1 << W)) begin : g_bad_counts
    $error("dssc_switch_control: cycle counts out of range");
  end

  localparam logic [W-1:0] HOLD_ON_LAST  = W'(HOLD_ON_CYCLES - 1);
  localparam logic [W-1:0] SLEEP_LAST    = W'(SLEEP_HOLD_CYCLES - 1);
  localparam logic [W-1:0] EDGE_ON_LAST  = W'(EDGE_ON_CYCLES - 1);
  localparam logic [W-1:0] EDGE_OFF_LAST = W'(EDGE_OFF_CYCLES - 1);
  localparam logic [W-1:0] STEP_LAST     = W'(RAMP_STEP_CYCLES - 1);
  localparam logic [W-1:0] CNT_ONE       = W'(1);
  localparam logic [W-1:0] CNT_MAX       = {W{1'b1}};

  logic                  hold_s;
  logic                  wake_s;
  logic                  sleep_s;
  logic                  hold_prev_reg;
  logic                  wake_prev_reg;
  logic                  sleep_prev_reg;
  logic                  hold_low;
  logic                  hold_rise;
  logic                  wake_rise;
  logic                  sleep_rise;
  dssc_pkg::dssc_state_t state_reg;
  dssc_pkg::dssc_state_t state_next;
  logic [W-1:0]          hold_cnt_reg;
  logic [W-1:0]          timer_reg;
  logic                  ramp_step;

  // Pins cross in from outside the clock domain; idle values avoid a false edge at reset
  dssc_sync #(.RESET_VAL(dssc_pkg::HOLD_IDLE)) u_sync_hold (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_enable (clock_enable),
    .async_in     (hold_button_n),
    .sync_out     (hold_s)
  );
  dssc_sync #(.RESET_VAL(dssc_pkg::EDGE_IDLE)) u_sync_wake (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_enable (clock_enable),
    .async_in     (wake_trigger),
    .sync_out     (wake_s)
  );
  dssc_sync #(.RESET_VAL(dssc_pkg::EDGE_IDLE)) u_sync_sleep (
    .clock        (clock),
    .reset_n      (reset_n),
    .clock_enable (clock_enable),
    .async_in     (sleep_trigger),
    .sync_out     (sleep_s)
  );

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      hold_prev_reg  <= dssc_pkg::HOLD_IDLE;
      wake_prev_reg  <= dssc_pkg::EDGE_IDLE;
      sleep_prev_reg <= dssc_pkg::EDGE_IDLE;
    end else if (clock_enable) begin
      hold_prev_reg  <= hold_s;
      wake_prev_reg  <= wake_s;
      sleep_prev_reg <= sleep_s;
    end
  end

  // Wake and sleep trigger only on edges; a held sleep level does nothing further, a held wake level blocks sleep edges; the button counts while low
  assign hold_low   = !hold_s;
  assign hold_rise  = hold_s && !hold_prev_reg;
  assign wake_rise  = wake_s && !wake_prev_reg;
  assign sleep_rise = sleep_s && !sleep_prev_reg;
  assign ramp_step  = (timer_reg == STEP_LAST);

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      dssc_pkg::DSSC_OFF: begin
        if (hold_low) begin
          if (hold_cnt_reg == HOLD_ON_LAST) state_next = dssc_pkg::DSSC_RAMP;
        end else if (wake_rise) begin
          state_next = dssc_pkg::DSSC_WAKE_DELAY;
        end
      end
      dssc_pkg::DSSC_WAKE_DELAY: begin
        // A pressed button outranks the pending wake; its own hold takes over
        if (hold_low) state_next = dssc_pkg::DSSC_OFF;
        else if (timer_reg == EDGE_ON_LAST) state_next = dssc_pkg::DSSC_RAMP;
      end
      dssc_pkg::DSSC_RAMP: begin
        if (ramp_level == dssc_pkg::RAMP_FULL && ramp_step) state_next = dssc_pkg::DSSC_ON;
      end
      dssc_pkg::DSSC_ON: begin
        if (hold_low) begin
          if (hold_cnt_reg == SLEEP_LAST) state_next = dssc_pkg::DSSC_OFF;
        end else if (sleep_rise && !wake_s) begin
          state_next = dssc_pkg::DSSC_SLEEP_DELAY;
        end
      end
      dssc_pkg::DSSC_SLEEP_DELAY: begin
        if (hold_rise || wake_rise) state_next = dssc_pkg::DSSC_ON;
        else if (hold_low) begin
          if (hold_cnt_reg == SLEEP_LAST) state_next = dssc_pkg::DSSC_OFF;
        end else if (timer_reg == EDGE_OFF_LAST) state_next = dssc_pkg::DSSC_OFF;
      end
      default: state_next = dssc_pkg::DSSC_OFF;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) state_reg <= dssc_pkg::DSSC_OFF;
    else if (clock_enable) state_reg <= state_next;
  end

  // Restarts on every state change, so a hold that switched on counts again from zero in DSSC_ON and can go on to sleep
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) hold_cnt_reg <= '0;
    else if (clock_enable) begin
      if (!hold_low || state_next != state_reg) hold_cnt_reg <= '0;
      else if (hold_cnt_reg != CNT_MAX) hold_cnt_reg <= hold_cnt_reg + CNT_ONE;
    end
  end

  // Shared delay timer; in the ramp it paces the level steps
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) timer_reg <= '0;
    else if (clock_enable) begin
      if (state_next != state_reg) timer_reg <= '0;
      else if (state_reg == dssc_pkg::DSSC_RAMP && ramp_step) timer_reg <= '0;
      else if (state_reg == dssc_pkg::DSSC_WAKE_DELAY || state_reg == dssc_pkg::DSSC_RAMP ||
               (state_reg == dssc_pkg::DSSC_SLEEP_DELAY && !hold_low)) timer_reg <= timer_reg + CNT_ONE;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) ramp_level <= dssc_pkg::RAMP_ZERO;
    else if (clock_enable) begin
      // Every turn-on starts the slew from zero, or a fresh ramp would jump straight to full
      if (state_next == dssc_pkg::DSSC_OFF || state_next == dssc_pkg::DSSC_WAKE_DELAY ||
          (state_next == dssc_pkg::DSSC_RAMP && state_reg != dssc_pkg::DSSC_RAMP))
        ramp_level <= dssc_pkg::RAMP_ZERO;
      else if (state_reg == dssc_pkg::DSSC_RAMP) begin
        if (ramp_step && ramp_level != dssc_pkg::RAMP_FULL) ramp_level <= ramp_level + 8'h01;
      end else ramp_level <= dssc_pkg::RAMP_FULL;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      switch_enable    <= 1'b0;
      discharge_enable <= 1'b1;
    end else if (clock_enable) begin
      switch_enable    <= !(state_next == dssc_pkg::DSSC_OFF || state_next == dssc_pkg::DSSC_WAKE_DELAY);
      discharge_enable <= state_next == dssc_pkg::DSSC_OFF || state_next == dssc_pkg::DSSC_WAKE_DELAY;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  sequence s_hold_done_off;
    clock_enable && state_reg == dssc_pkg::DSSC_OFF && hold_low && hold_cnt_reg == HOLD_ON_LAST;
  endsequence
  sequence s_hold_done_on;
    clock_enable && state_reg == dssc_pkg::DSSC_ON && hold_low && hold_cnt_reg == SLEEP_LAST;
  endsequence
  sequence s_wake_edge;
    clock_enable && state_reg == dssc_pkg::DSSC_OFF && !hold_low && wake_rise;
  endsequence
  sequence s_sleep_edge;
    clock_enable && state_reg == dssc_pkg::DSSC_ON && !hold_low && !wake_s && sleep_rise;
  endsequence
  sequence s_wake_timeout;
    clock_enable && state_reg == dssc_pkg::DSSC_WAKE_DELAY && !hold_low && timer_reg == EDGE_ON_LAST;
  endsequence

  property p_hold_on;
    s_hold_done_off |=> state_reg == dssc_pkg::DSSC_RAMP && switch_enable && !discharge_enable &&
      ramp_level == dssc_pkg::RAMP_ZERO;
  endproperty
  a_hold_on: assert property (p_hold_on) else $error("hold did not switch on");

  property p_hold_sleep;
    s_hold_done_on |=> state_reg == dssc_pkg::DSSC_OFF && !switch_enable && ramp_level == dssc_pkg::RAMP_ZERO;
  endproperty
  a_hold_sleep: assert property (p_hold_sleep) else $error("hold did not enter sleep");

  property p_wake_delay;
    s_wake_timeout |=> state_reg == dssc_pkg::DSSC_RAMP && switch_enable && ramp_level == dssc_pkg::RAMP_ZERO;
  endproperty
  a_wake_delay: assert property (p_wake_delay) else $error("wake delay end missed");

  property p_wake_start;
    s_wake_edge |=> state_reg == dssc_pkg::DSSC_WAKE_DELAY && timer_reg == '0 && !switch_enable;
  endproperty
  a_wake_start: assert property (p_wake_start) else $error("wake edge not taken");

  property p_sleep_start;
    s_sleep_edge |=> state_reg == dssc_pkg::DSSC_SLEEP_DELAY && switch_enable;
  endproperty
  a_sleep_start: assert property (p_sleep_start) else $error("sleep edge not taken");

  property p_discharge;
    discharge_enable == !switch_enable;
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge and switch overlap");

  property p_ramp_full;
    $fell(state_reg == dssc_pkg::DSSC_RAMP) && state_reg == dssc_pkg::DSSC_ON |-> $past(ramp_level) == dssc_pkg::RAMP_FULL;
  endproperty
  a_ramp_full: assert property (p_ramp_full) else $error("ramp ended early");

  property p_ramp_rise;
    state_reg == dssc_pkg::DSSC_RAMP && $past(state_reg) == dssc_pkg::DSSC_RAMP |-> ramp_level >= $past(ramp_level);
  endproperty
  a_ramp_rise: assert property (p_ramp_rise) else $error("ramp level fell");

  property p_priority;
    clock_enable && state_reg == dssc_pkg::DSSC_ON && hold_low && sleep_rise |=> state_reg != dssc_pkg::DSSC_SLEEP_DELAY;
  endproperty
  a_priority: assert property (p_priority) else $error("sleep edge beat the button");

  property p_release_keeps_on;
    clock_enable && state_reg == dssc_pkg::DSSC_ON && hold_rise && !sleep_rise |=>
      state_reg == dssc_pkg::DSSC_ON && hold_cnt_reg == '0;
  endproperty
  a_release_keeps_on: assert property (p_release_keeps_on) else $error("release did not keep on");

  property p_cancel;
    clock_enable && state_reg == dssc_pkg::DSSC_SLEEP_DELAY && hold_rise |=> state_reg == dssc_pkg::DSSC_ON ##1
      state_reg != dssc_pkg::DSSC_OFF;
  endproperty
  a_cancel: assert property (p_cancel) else $error("button release did not cancel turn-off");
endmodule : dssc_switch_control

`default_nettype wire

//--- dssc_sync.sv
`timescale 1ns/1ns
`default_nettype none

package dssc_pkg;
  localparam int CLK_FREQ_HZ         = 20_000_000;
  localparam int CYC_PER_US          = CLK_FREQ_HZ / 1_000_000;
  // Times in microseconds
  localparam int HOLD_ON_TIME_US     = 300_000;
  localparam int SLEEP_HOLD_TIME_US  = 1_800_000;
  localparam int EDGE_ON_DELAY_US    = 800;
  localparam int EDGE_OFF_DELAY_US   = 1_800_000;
  localparam int OUTPUT_RAMP_TIME_US = 1_000;
  // Whole microseconds give exact cycle counts at this rate
  localparam int HOLD_ON_CYCLES      = HOLD_ON_TIME_US * CYC_PER_US;
  localparam int SLEEP_HOLD_CYCLES   = SLEEP_HOLD_TIME_US * CYC_PER_US;
  localparam int EDGE_ON_CYCLES      = EDGE_ON_DELAY_US * CYC_PER_US;
  localparam int EDGE_OFF_CYCLES     = EDGE_OFF_DELAY_US * CYC_PER_US;
  localparam int RAMP_CYCLES         = OUTPUT_RAMP_TIME_US * CYC_PER_US;
  localparam int CNT_W               = 26;
  localparam int RAMP_W              = 8;
  localparam logic [7:0] RAMP_FULL   = 8'hff;
  localparam logic [7:0] RAMP_ZERO   = 8'h00;
  localparam logic HOLD_IDLE         = 1'b1;
  localparam logic EDGE_IDLE         = 1'b0;

  typedef enum logic [2:0] {
    DSSC_OFF,
    DSSC_WAKE_DELAY,
    DSSC_RAMP,
    DSSC_ON,
    DSSC_SLEEP_DELAY
  } dssc_state_t;
endpackage : dssc_pkg

module dssc_sync #(
  parameter logic RESET_VAL = 1'b0
) (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic clock_enable,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_reg;

  // Only the second stage reads the first
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= RESET_VAL;
      sync_out <= RESET_VAL;
    end else if (clock_enable) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end
endmodule : dssc_sync

`default_nettype wire

//--- dssc_partner.sv
`timescale 1ns/1ns
`default_nettype none

module dssc_partner (
  input  wire logic press,
  input  wire logic wake_val,
  input  wire logic sleep_val,
  input  wire logic edge_oe,
  output logic      hold_button_n,
  output logic      wake_trigger,
  output logic      sleep_trigger
);
  // Key button against a pull-up: low only while pressed
  assign hold_button_n = press ? 1'b0 : 1'b1;
  // A released edge line settles to its pull-down level, never to a stale value
  assign wake_trigger  = edge_oe ? wake_val : 1'b0;
  assign sleep_trigger = edge_oe ? sleep_val : 1'b0;
endmodule : dssc_partner

`default_nettype wire

//--- tb_top.sv
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  // Short counts keep the run small; ramp step is RMP/255 = 2 cycles
  localparam int H = 20;
  localparam int S = 40;
  localparam int EON = 10;
  localparam int EOFF = 30;
  localparam int RMP = 510;
  typedef struct packed {logic [3:0] mask; int hold; logic exp; int min; int win;} dssc_row_t;
  logic                          clock, reset_n, clock_enable, press, wake_val, sleep_val, edge_oe;
  wire logic                     hold_button_n, wake_trigger, sleep_trigger;
  logic                          switch_enable, discharge_enable;
  logic [dssc_pkg::RAMP_W-1:0]   ramp_level;
  int                            fail_count, checks, cycles;
  // mask: bit0 button, bit1 wake, bit2 sleep, bit3 edge lines released
  dssc_row_t rows [9] = '{
    '{4'h1, 15, 1'b0, 0, 40},
    '{4'ha, 20, 1'b0, 0, 40},
    '{4'h3, 5, 1'b0, 0, 60},
    '{4'h1, 30, 1'b1, H, 600},
    '{4'h1, 30, 1'b1, 0, 60},
    '{4'h6, 5, 1'b1, 0, 60},
    '{4'h1, 50, 1'b0, S, 80},
    '{4'h2, 5, 1'b1, EON, 600},
    '{4'h4, 5, 1'b0, EOFF, 60}
  };

  dssc_switch_control #(
    .HOLD_ON_CYCLES    (H),
    .SLEEP_HOLD_CYCLES (S),
    .EDGE_ON_CYCLES    (EON),
    .EDGE_OFF_CYCLES   (EOFF),
    .RAMP_CYCLES       (RMP)
  ) dut_u (
    .clock            (clock),
    .reset_n          (reset_n),
    .clock_enable     (clock_enable),
    .hold_button_n    (hold_button_n),
    .wake_trigger     (wake_trigger),
    .sleep_trigger    (sleep_trigger),
    .switch_enable    (switch_enable),
    .discharge_enable (discharge_enable),
    .ramp_level       (ramp_level)
  );

  dssc_partner part_u (
    .press         (press),
    .wake_val      (wake_val),
    .sleep_val     (sleep_val),
    .edge_oe       (edge_oe),
    .hold_button_n (hold_button_n),
    .wake_trigger  (wake_trigger),
    .sleep_trigger (sleep_trigger)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task print_verdict();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : print_verdict

  // A hang costs one mismatch and still reaches the report
  always @(posedge clock) begin
    cycles++;
    if (cycles == 10000) begin
      fail_count++;
      print_verdict();
    end
  end

  task chk(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Drives one stimulus for r.hold cycles and watches the switch for r.win cycles
  task run_row(input dssc_row_t r);
    int first;
    first = -1;
    for (int i = 0; i < r.win; i++) begin
      @(posedge clock);
      #5;
      press     = r.mask[0] && (i < r.hold);
      wake_val  = r.mask[1] && (i < r.hold);
      sleep_val = r.mask[2] && (i < r.hold);
      edge_oe   = !r.mask[3];
      if (first < 0 && switch_enable === r.exp) begin
        first = i;
      end
    end
    chk(8'(switch_enable), 8'(r.exp));
    chk(8'(first >= r.min && first <= r.min + 8), 8'h01);
    chk(8'(discharge_enable), 8'(!r.exp));
  endtask : run_row

  task check_off();
    chk(8'(switch_enable), 8'h00);
    chk(8'(discharge_enable), 8'h01);
    chk(ramp_level, dssc_pkg::RAMP_ZERO);
  endtask : check_off

  initial begin
    cycles = 0;
    fail_count = 0;
    checks = 0;
    reset_n = 1'b0;
    clock_enable = 1'b1;
    press = 1'b0;
    wake_val = 1'b0;
    sleep_val = 1'b0;
    edge_oe = 1'b1;
    repeat (4) @(posedge clock);
    #5;
    check_off();
    reset_n = 1'b1;
    for (int k = 0; k < 9; k++) begin
      run_row(rows[k]);
    end
    // Frozen time base: a long press must not count
    clock_enable = 1'b0;
    run_row('{4'h1, 60, 1'b0, 0, 70});
    clock_enable = 1'b1;
    run_row('{4'h0, 0, 1'b0, 0, 10});
    // Ramp is part way up early and full later
    run_row('{4'h2, 5, 1'b1, EON, 120});
    chk(8'(ramp_level != 8'h00 && ramp_level != 8'hff), 8'h01);
    repeat (500) @(posedge clock);
    #5;
    chk(ramp_level, dssc_pkg::RAMP_FULL);
    // Button release cancels a pending turn-off; a new sleep edge restarts it
    run_row('{4'h4, 5, 1'b1, 0, 15});
    run_row('{4'h1, 3, 1'b1, 0, 60});
    run_row('{4'h4, 5, 1'b0, EOFF, 60});
    // Power loss in mid-run returns to the off state
    run_row('{4'h2, 5, 1'b1, EON, 40});
    reset_n = 1'b0;
    @(posedge clock);
    #5;
    check_off();
    reset_n = 1'b1;
    // Two edges after release the switch must still be off with idle pins
    repeat (2) @(posedge clock);
    #5;
    check_off();
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
